// ===== hdl/power_protection_pkg.sv
package power_protection_pkg;

  // Register indices on the plain register port
  localparam logic [7:0] ADDR_STATUS      = 8'h00;
  localparam logic [7:0] ADDR_ALERT_EN    = 8'h01;
  localparam logic [7:0] ADDR_CONFIG      = 8'h02;
  localparam logic [7:0] ADDR_SOFT_THR    = 8'h03;
  localparam logic [7:0] ADDR_RECT_THR    = 8'h04;
  localparam logic [7:0] ADDR_REG_THR     = 8'h05;
  localparam logic [7:0] ADDR_COIL_THR    = 8'h06;
  localparam logic [7:0] ADDR_RECT_ACT    = 8'h07;
  localparam logic [7:0] ADDR_REG_ACT     = 8'h08;
  localparam logic [7:0] ADDR_COIL_ACT    = 8'h09;
  localparam logic [7:0] ADDR_OCP_ACT     = 8'h0a;
  localparam logic [7:0] ADDR_LOAD_THR    = 8'h0b;
  localparam logic [7:0] ADDR_LOAD_ACT    = 8'h0c;
  localparam logic [7:0] ADDR_RECT_TEMP   = 8'h0d;
  localparam logic [7:0] ADDR_REG_TEMP    = 8'h0e;
  localparam logic [7:0] ADDR_VOUT_SET    = 8'h0f;
  localparam logic [7:0] ADDR_RAIL_MIN    = 8'h10;
  localparam logic [7:0] ADDR_DUMMY_SET   = 8'h11;
  localparam logic [7:0] ADDR_STATE       = 8'h12;

  // Status flag positions
  localparam int FLAG_HARD_OV   = 0;
  localparam int FLAG_SOFT_OV   = 1;
  localparam int FLAG_ADJ_OV    = 2;
  localparam int FLAG_CHIP_OT   = 3;
  localparam int FLAG_RECT_TEMP = 4;
  localparam int FLAG_REG_TEMP  = 5;
  localparam int FLAG_COIL_TEMP = 6;
  localparam int FLAG_OCP       = 7;
  localparam int FLAG_UVLO      = 8;
  localparam int FLAG_OVERLOAD  = 9;
  localparam int FLAG_COUNT     = 10;

  // Action set bit positions
  localparam int ACT_EPT        = 0;
  localparam int ACT_DISCONNECT = 1;
  localparam int ACT_ALERT      = 2;

  // Configuration bit positions
  localparam int CFG_EPT_ON_OV  = 0;
  localparam int CFG_DUMMY_EN   = 1;
  localparam int CFG_ALERT_OD   = 2;
  localparam int CFG_ALERT_POL  = 3;

  // Reset values
  localparam logic [15:0] SOFT_THR_RESET  = 16'h2ee0;
  localparam logic [15:0] VOUT_SET_RESET  = 16'h00c8;
  localparam logic [15:0] RAIL_MIN_RESET  = 16'h1400;
  localparam logic [15:0] TEMP_THR_RESET  = 16'h0064;

  // Fixed chip over-temperature trip, degrees
  localparam logic [15:0] CHIP_OT_TRIP    = 16'd125;
  localparam logic [15:0] CHIP_OT_HYST    = 16'd10;

  // Configuration reload length in words
  localparam int RELOAD_WORDS = 8;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_RESET  = 2'b00,
    SEQ_RELOAD = 2'b01,
    SEQ_RUN    = 2'b10
  } seq_state_type;

endpackage : power_protection_pkg

// ===== hdl/power_protection_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

module power_protection_supervisor
  import power_protection_pkg::*;
#(
  parameter int DATA_WIDTH = 16,
  parameter int DUMMY_STEP = 16
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  chip_reset_n,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [DATA_WIDTH-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [DATA_WIDTH-1:0] reg_rdata,
  // OTP reload port
  output logic                       otp_read,
  output logic      [2:0]            otp_addr,
  input  wire logic [DATA_WIDTH-1:0] otp_data,
  // Comparator trips
  input  wire logic                  hard_clamp_trip,
  input  wire logic                  fixed_soft_trip,
  input  wire logic                  five_volt_good,
  input  wire logic                  current_limit_trip,
  input  wire logic                  output_uv_trip,
  // Converter
  output logic      [1:0]            adc_channel,
  input  wire logic                  adc_valid,
  input  wire logic [DATA_WIDTH-1:0] adc_value,
  input  wire logic [DATA_WIDTH-1:0] rectifier_rail,
  input  wire logic [DATA_WIDTH-1:0] output_current,
  // Protection actions
  output logic                       hard_protection_event,
  output logic                       clamp_sink_out_n,
  output logic                       ept_request,
  output logic                       output_disconnect,
  output logic                       regulator_disable,
  // Host alert line
  output logic                       host_alert_out,
  output logic                       host_alert_oe,
  // Regulation setpoints
  output logic      [DATA_WIDTH-1:0] vout_target,
  output logic      [DATA_WIDTH-1:0] rect_rail_min,
  output logic      [DATA_WIDTH-1:0] dummy_current,
  output logic      [1:0]            drive_scheme,
  output logic                       core_ready
);

  logic                  core_rst_n;
  logic [1:0]            rst_sync_reg;
  seq_state_type         seq_reg;
  logic [2:0]            load_idx_reg;
  logic                  run;
  logic [4:0]            trip_s1_reg;
  logic [4:0]            trip_s2_reg;
  logic                  hard_trip;
  logic                  fixed_trip;
  logic                  vgood;
  logic                  ocp_trip;
  logic                  uv_trip;
  logic [FLAG_COUNT-1:0] status_reg;
  logic [FLAG_COUNT-1:0] status_next;
  logic [FLAG_COUNT-1:0] events;
  logic [FLAG_COUNT-1:0] alert_en_reg;
  logic [3:0]            config_reg;
  logic [DATA_WIDTH-1:0] soft_thr_reg;
  logic [DATA_WIDTH-1:0] rect_thr_reg;
  logic [DATA_WIDTH-1:0] reg_thr_reg;
  logic [DATA_WIDTH-1:0] coil_thr_reg;
  logic [2:0]            rect_act_reg;
  logic [2:0]            reg_act_reg;
  logic [2:0]            coil_act_reg;
  logic [2:0]            ocp_act_reg;
  logic [2:0]            load_act_reg;
  logic [DATA_WIDTH-1:0] load_thr_reg;
  logic [DATA_WIDTH-1:0] rect_temp_reg;
  logic [DATA_WIDTH-1:0] reg_temp_reg;
  logic [DATA_WIDTH-1:0] coil_temp_reg;
  logic [DATA_WIDTH-1:0] vout_set_reg;
  logic [DATA_WIDTH-1:0] rail_min_reg;
  logic [DATA_WIDTH-1:0] dummy_set_reg;
  logic                  clamp_reg;
  logic                  chip_ot_reg;
  logic                  adj_ov;
  logic [2:0]            actions;
  logic                  any_ov;
  logic                  alert;
  logic [DATA_WIDTH-1:0] dummy_cut;

  function automatic logic [2:0] act_if(input logic hit,
                                        input logic [2:0] act);
    act_if = hit ? act : 3'h0;
  endfunction : act_if

  // Core reset from both reset inputs, released asynchronously; sequencer start waits two clocks
  assign core_rst_n = reset_n & chip_reset_n;
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Reload sequencer
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      seq_reg      <= SEQ_RESET;
      load_idx_reg <= 3'h0;
    end else begin
      unique case (seq_reg)
        SEQ_RESET: begin
          if (rst_sync_reg[1]) begin
            seq_reg <= SEQ_RELOAD;
          end
        end
        SEQ_RELOAD: begin
          load_idx_reg <= load_idx_reg + 3'h1;
          if (load_idx_reg == 3'(RELOAD_WORDS - 1)) begin
            seq_reg <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          seq_reg <= SEQ_RUN;
        end
        default: begin
          seq_reg <= SEQ_RESET;
        end
      endcase
    end
  end
  assign run        = (seq_reg == SEQ_RUN);
  assign core_ready = run;
  assign otp_read   = (seq_reg == SEQ_RELOAD);
  assign otp_addr   = load_idx_reg;

  // Two-stage synchronisers for comparator trips
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      trip_s1_reg <= 5'h00;
      trip_s2_reg <= 5'h00;
    end else begin
      trip_s1_reg <= {output_uv_trip, current_limit_trip, five_volt_good,
                      fixed_soft_trip, hard_clamp_trip};
      trip_s2_reg <= trip_s1_reg;
    end
  end
  assign hard_trip  = trip_s2_reg[0];
  assign fixed_trip = trip_s2_reg[1];
  assign vgood      = trip_s2_reg[2];
  assign ocp_trip   = trip_s2_reg[3];
  assign uv_trip    = trip_s2_reg[4];

  // Converter channel rotation and temperature capture
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      adc_channel   <= 2'h0;
      rect_temp_reg <= '0;
      reg_temp_reg  <= '0;
      coil_temp_reg <= '0;
    end else if (adc_valid) begin
      adc_channel <= (adc_channel == 2'h2) ? 2'h0 : adc_channel + 2'h1;
      unique case (adc_channel)
        2'h0: rect_temp_reg <= adc_value;
        2'h1: reg_temp_reg  <= adc_value;
        2'h2: coil_temp_reg <= adc_value;
        default: begin
        end
      endcase
    end
  end

  // Fixed chip over-temperature with hysteresis
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      chip_ot_reg <= 1'b0;
    end else if ((rect_temp_reg >= CHIP_OT_TRIP) ||
                 (reg_temp_reg >= CHIP_OT_TRIP)) begin
      chip_ot_reg <= 1'b1;
    end else if ((rect_temp_reg < CHIP_OT_TRIP - CHIP_OT_HYST) &&
                 (reg_temp_reg < CHIP_OT_TRIP - CHIP_OT_HYST)) begin
      chip_ot_reg <= 1'b0;
    end
  end

  // Hard clamp set by trip, released on loss of power-good
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      clamp_reg <= 1'b0;
    end else if (hard_trip || chip_ot_reg) begin
      clamp_reg <= 1'b1;
    end else if (!vgood) begin
      clamp_reg <= 1'b0;
    end
  end
  assign hard_protection_event = hard_trip | chip_ot_reg | clamp_reg;

  // Overvoltage checks
  assign adj_ov           = run && (rectifier_rail > soft_thr_reg);
  assign clamp_sink_out_n = !(fixed_trip || adj_ov);
  assign any_ov           = hard_trip | fixed_trip | adj_ov;

  // Events feeding the sticky flags
  always_comb begin
    events                 = '0;
    events[FLAG_HARD_OV]   = hard_trip;
    events[FLAG_SOFT_OV]   = fixed_trip;
    events[FLAG_ADJ_OV]    = adj_ov;
    events[FLAG_CHIP_OT]   = chip_ot_reg;
    events[FLAG_RECT_TEMP] = run && (rect_temp_reg > rect_thr_reg);
    events[FLAG_REG_TEMP]  = run && (reg_temp_reg > reg_thr_reg);
    events[FLAG_COIL_TEMP] = run && (coil_temp_reg > coil_thr_reg);
    events[FLAG_OCP]       = ocp_trip;
    events[FLAG_UVLO]      = uv_trip;
    events[FLAG_OVERLOAD]  = run && (output_current > load_thr_reg);
  end

  // Sticky flags, write one to clear, set wins
  always_comb begin
    status_next = status_reg;
    if (reg_write && reg_addr == ADDR_STATUS) begin
      status_next = status_reg & ~reg_wdata[FLAG_COUNT-1:0];
    end
    status_next = status_next | events;
  end
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Action sets
  assign actions =
      act_if(status_reg[FLAG_RECT_TEMP], rect_act_reg) |
      act_if(status_reg[FLAG_REG_TEMP], reg_act_reg) |
      act_if(status_reg[FLAG_COIL_TEMP], coil_act_reg) |
      act_if(status_reg[FLAG_OCP], ocp_act_reg) |
      act_if(status_reg[FLAG_OVERLOAD], load_act_reg);

  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ept_request       <= 1'b0;
      output_disconnect <= 1'b0;
      regulator_disable <= 1'b0;
    end else begin
      ept_request <= actions[ACT_EPT] |
                     (config_reg[CFG_EPT_ON_OV] & any_ov);
      output_disconnect <= actions[ACT_DISCONNECT];
      regulator_disable <= uv_trip | status_reg[FLAG_UVLO];
    end
  end

  // Host alert line
  assign alert = |(status_reg & alert_en_reg) | actions[ACT_ALERT];
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      host_alert_out <= 1'b1;
      host_alert_oe  <= 1'b1;
    end else if (config_reg[CFG_ALERT_OD]) begin
      host_alert_out <= 1'b0;
      host_alert_oe  <= alert;
    end else begin
      host_alert_out <= alert ^ !config_reg[CFG_ALERT_POL];
      host_alert_oe  <= 1'b1;
    end
  end

  // Dummy load stepping down with output current
  assign dummy_cut = output_current / DATA_WIDTH'(DUMMY_STEP);
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      dummy_current <= '0;
    end else if (!config_reg[CFG_DUMMY_EN] || !run) begin
      dummy_current <= '0;
    end else if (dummy_cut >= dummy_set_reg) begin
      dummy_current <= '0;
    end else begin
      dummy_current <= dummy_set_reg - dummy_cut;
    end
  end

  // Setpoints and drive scheme
  assign vout_target   = vout_set_reg;
  assign rect_rail_min = rail_min_reg;
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      drive_scheme <= 2'h0;
    end else if (output_current > (load_thr_reg >> 1)) begin
      drive_scheme <= 2'h2;
    end else if (output_current > (load_thr_reg >> 3)) begin
      drive_scheme <= 2'h1;
    end else begin
      drive_scheme <= 2'h0;
    end
  end

  // Configuration registers, loaded from OTP then from software
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      alert_en_reg  <= '0;
      config_reg    <= 4'h0;
      soft_thr_reg  <= SOFT_THR_RESET;
      rect_thr_reg  <= TEMP_THR_RESET;
      reg_thr_reg   <= TEMP_THR_RESET;
      coil_thr_reg  <= '1;
      rect_act_reg  <= 3'h0;
      reg_act_reg   <= 3'h0;
      coil_act_reg  <= 3'h0;
      ocp_act_reg   <= 3'h0;
      load_act_reg  <= 3'h0;
      load_thr_reg  <= '1;
      vout_set_reg  <= VOUT_SET_RESET;
      rail_min_reg  <= RAIL_MIN_RESET;
      dummy_set_reg <= '0;
    end else if (seq_reg == SEQ_RELOAD) begin
      unique case (load_idx_reg)
        3'h0: config_reg    <= otp_data[3:0];
        3'h1: soft_thr_reg  <= otp_data;
        3'h2: vout_set_reg  <= otp_data;
        3'h3: rail_min_reg  <= otp_data;
        3'h4: dummy_set_reg <= otp_data;
        3'h5: rect_thr_reg  <= otp_data;
        3'h6: reg_thr_reg   <= otp_data;
        3'h7: coil_thr_reg  <= otp_data;
        default: begin
        end
      endcase
    end else if (reg_write) begin
      unique case (reg_addr)
        ADDR_ALERT_EN:  alert_en_reg  <= reg_wdata[FLAG_COUNT-1:0];
        ADDR_CONFIG:    config_reg    <= reg_wdata[3:0];
        ADDR_SOFT_THR:  soft_thr_reg  <= reg_wdata;
        ADDR_RECT_THR:  rect_thr_reg  <= reg_wdata;
        ADDR_REG_THR:   reg_thr_reg   <= reg_wdata;
        ADDR_COIL_THR:  coil_thr_reg  <= reg_wdata;
        ADDR_RECT_ACT:  rect_act_reg  <= reg_wdata[2:0];
        ADDR_REG_ACT:   reg_act_reg   <= reg_wdata[2:0];
        ADDR_COIL_ACT:  coil_act_reg  <= reg_wdata[2:0];
        ADDR_OCP_ACT:   ocp_act_reg   <= reg_wdata[2:0];
        ADDR_LOAD_THR:  load_thr_reg  <= reg_wdata;
        ADDR_LOAD_ACT:  load_act_reg  <= reg_wdata[2:0];
        ADDR_VOUT_SET:  vout_set_reg  <= reg_wdata;
        ADDR_RAIL_MIN:  rail_min_reg  <= reg_wdata;
        ADDR_DUMMY_SET: dummy_set_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADDR_STATUS:    reg_rdata <= DATA_WIDTH'(status_reg);
        ADDR_ALERT_EN:  reg_rdata <= DATA_WIDTH'(alert_en_reg);
        ADDR_CONFIG:    reg_rdata <= DATA_WIDTH'(config_reg);
        ADDR_SOFT_THR:  reg_rdata <= soft_thr_reg;
        ADDR_RECT_THR:  reg_rdata <= rect_thr_reg;
        ADDR_REG_THR:   reg_rdata <= reg_thr_reg;
        ADDR_COIL_THR:  reg_rdata <= coil_thr_reg;
        ADDR_RECT_ACT:  reg_rdata <= DATA_WIDTH'(rect_act_reg);
        ADDR_REG_ACT:   reg_rdata <= DATA_WIDTH'(reg_act_reg);
        ADDR_COIL_ACT:  reg_rdata <= DATA_WIDTH'(coil_act_reg);
        ADDR_OCP_ACT:   reg_rdata <= DATA_WIDTH'(ocp_act_reg);
        ADDR_LOAD_THR:  reg_rdata <= load_thr_reg;
        ADDR_LOAD_ACT:  reg_rdata <= DATA_WIDTH'(load_act_reg);
        ADDR_RECT_TEMP: reg_rdata <= rect_temp_reg;
        ADDR_REG_TEMP:  reg_rdata <= reg_temp_reg;
        ADDR_VOUT_SET:  reg_rdata <= vout_set_reg;
        ADDR_RAIL_MIN:  reg_rdata <= rail_min_reg;
        ADDR_DUMMY_SET: reg_rdata <= dummy_set_reg;
        ADDR_STATE:     reg_rdata <= DATA_WIDTH'({clamp_reg, seq_reg});
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Assertions
  default clocking assert_clk @(posedge clk_sys);
  endclocking
  default disable iff (!core_rst_n);

  sequence hard_seen_s;
    hard_trip;
  endsequence
  sequence reload_done_s;
    otp_read [*8] ##1 core_ready;
  endsequence

  clamp_holds_a: assert property (hard_seen_s ##1 vgood |-> clamp_reg)
    else $error("Clamp released while five-volt rail good");
  clamp_sets_a: assert property (
    hard_seen_s |-> hard_protection_event ##1 clamp_reg)
    else $error("Hard trip did not clamp");
  sync_delay_a: assert property ($rose(trip_s1_reg[0]) |=> hard_trip)
    else $error("Synchroniser stage missing");
  sink_low_a: assert property (
    (fixed_trip || adj_ov) |-> !clamp_sink_out_n)
    else $error("Sink not driven on soft overvoltage");
  ept_ov_a: assert property (
    (config_reg[CFG_EPT_ON_OV] && any_ov) |=> ept_request)
    else $error("No end-of-power request on overvoltage");
  flag_sticky_a: assert property (
    events[FLAG_OCP] |=> status_reg[FLAG_OCP])
    else $error("Event flag lost");
  uv_disable_a: assert property (uv_trip |=> regulator_disable)
    else $error("Regulator not disabled on undervoltage");
  reload_len_a: assert property ($rose(otp_read) |-> reload_done_s)
    else $error("Reload length wrong");
  chip_ot_a: assert property (
    (rect_temp_reg >= CHIP_OT_TRIP) |=> chip_ot_reg)
    else $error("Chip over-temperature missed");

endmodule : power_protection_supervisor

`default_nettype wire

// ===== tb/otp_model.sv
`timescale 1ns/1ps
`default_nettype none
module otp_model (
  // Clock
  input  wire logic        clk_sys,
  // Reload port
  input  wire logic        otp_read,
  input  wire logic [2:0]  otp_addr,
  output logic      [15:0] otp_data
);
  logic toggle = 1'b0;
  always @(posedge clk_sys) begin
    toggle <= ~toggle;
  end
  // Config, soft thr, vout, rectifier_rail min, dummy, temp thresholds
  always_comb begin
    case (otp_addr)
      3'd0: otp_data = 16'h0001;
      3'd1: otp_data = 16'h2ee0;
      3'd2: otp_data = 16'h0123;
      3'd3: otp_data = 16'h0456;
      3'd4: otp_data = 16'h0000;
      default: otp_data = 16'h0064;
    endcase
    if (!otp_read) otp_data = {16{toggle}};
  end
endmodule : otp_model
`default_nettype wire

// ===== tb/tb_power_protection_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_power_protection_supervisor;
  import power_protection_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, chip_reset_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, adc_value = 16'h0000;
  logic [15:0] rectifier_rail = 16'h1000, output_current = 16'h0000;
  logic reg_write = 1'b0, reg_read = 1'b0, adc_valid = 1'b0;
  logic hard_clamp_trip = 1'b0, fixed_soft_trip = 1'b0;
  logic five_volt_good = 1'b1, current_limit_trip = 1'b0;
  logic output_uv_trip = 1'b0;
  logic [15:0] reg_rdata, otp_data, vout_target, rect_rail_min, dummy_current;
  logic [2:0] otp_addr;
  logic [1:0] adc_channel, drive_scheme;
  logic otp_read, hard_protection_event, clamp_sink_out_n, ept_request;
  logic output_disconnect, regulator_disable, host_alert_out;
  logic host_alert_oe, core_ready;
  int mismatches = 0, check_count = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  power_protection_supervisor dut (.clk_sys, .reset_n, .chip_reset_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .otp_read,
    .otp_addr, .otp_data, .hard_clamp_trip, .fixed_soft_trip,
    .five_volt_good, .current_limit_trip, .output_uv_trip, .adc_channel,
    .adc_valid, .adc_value, .rectifier_rail, .output_current,
    .hard_protection_event, .clamp_sink_out_n, .ept_request,
    .output_disconnect, .regulator_disable, .host_alert_out,
    .host_alert_oe, .vout_target, .rect_rail_min, .dummy_current,
    .drive_scheme, .core_ready);
  otp_model otp (.clk_sys, .otp_read, .otp_addr, .otp_data);

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_n

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic adc(input logic [15:0] v);
    @(posedge clk_sys);
    adc_valid <= 1'b1;
    adc_value <= v;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
  endtask : adc

  task automatic boot;
    int n;
    logic [15:0] d;
    n = 0;
    check(core_ready, 16'h0000);
    check(clamp_sink_out_n, 16'h0001);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    chip_reset_n <= 1'b1;
    for (int i = 0; i < 60 && core_ready !== 1'b1; i++) begin
      wait_n(1);
      if (otp_read === 1'b1) n++;
    end
    check(16'(n), 16'(RELOAD_WORDS));
    check(vout_target, 16'h0123);
    check(rect_rail_min, 16'h0456);
    rd(ADDR_SOFT_THR, d);
    check(d, 16'h2ee0);
    $display("boot done");
  endtask : boot

  task automatic test_hard;
    logic [15:0] d;
    wr(ADDR_ALERT_EN, 16'h0001);
    hard_clamp_trip <= 1'b1;
    wait_n(4);
    check(hard_protection_event, 16'h0001);
    check({host_alert_out, host_alert_oe}, 16'h0001);
    @(posedge clk_sys);
    hard_clamp_trip <= 1'b0;
    wait_n(4);
    check(hard_protection_event, 16'h0001);
    five_volt_good <= 1'b0;
    wait_n(4);
    check(hard_protection_event, 16'h0000);
    five_volt_good <= 1'b1;
    rd(ADDR_STATUS, d);
    check(d & 16'h0001, 16'h0001);
    wr(ADDR_STATUS, 16'h03ff);
    wait_n(3);
    check(host_alert_out, 16'h0001);
    $display("test_hard done");
  endtask : test_hard

  task automatic test_soft;
    logic [15:0] d;
    fixed_soft_trip <= 1'b1;
    wait_n(4);
    check(clamp_sink_out_n, 16'h0000);
    check(ept_request, 16'h0001);
    fixed_soft_trip <= 1'b0;
    rectifier_rail <= 16'h2ee1;
    wait_n(4);
    check(clamp_sink_out_n, 16'h0000);
    rectifier_rail <= 16'h2edf;
    wait_n(4);
    check(clamp_sink_out_n, 16'h0001);
    rd(ADDR_STATUS, d);
    check(d & 16'h0006, 16'h0006);
    wr(ADDR_STATUS, 16'h03ff);
    $display("test_soft done");
  endtask : test_soft

  task automatic test_ot;
    logic [15:0] d;
    five_volt_good <= 1'b0;
    adc(16'd126);
    wait_n(3);
    check(hard_protection_event, 16'h0001);
    check(adc_channel, 16'h0001);
    adc(16'd20);
    adc(16'd20);
    adc(16'd120);
    wait_n(3);
    check(hard_protection_event, 16'h0001);
    adc(16'd20);
    adc(16'd20);
    adc(16'd100);
    wait_n(3);
    check(hard_protection_event, 16'h0000);
    rd(ADDR_RECT_TEMP, d);
    check(d, 16'd100);
    rd(ADDR_REG_TEMP, d);
    check(d, 16'd20);
    rd(ADDR_STATUS, d);
    check(d & 16'h0010, 16'h0010);
    five_volt_good <= 1'b1;
    wr(ADDR_STATUS, 16'h03ff);
    $display("test_ot done");
  endtask : test_ot

  task automatic test_load;
    logic [15:0] d;
    wr(ADDR_DUMMY_SET, 16'h0040);
    wr(ADDR_CONFIG, 16'h0006);
    output_current <= 16'h0100;
    wait_n(2);
    check(dummy_current, 16'h0030);
    check(drive_scheme, 16'h0000);
    wr(ADDR_LOAD_THR, 16'h0400);
    wr(ADDR_LOAD_ACT, 16'h0004);
    wait_n(2);
    check(drive_scheme, 16'h0001);
    output_current <= 16'h0500;
    wait_n(3);
    check(drive_scheme, 16'h0002);
    check(dummy_current, 16'h0000);
    check({host_alert_out, host_alert_oe}, 16'h0001);
    rd(ADDR_STATUS, d);
    check(d & 16'h0200, 16'h0200);
    output_current <= 16'h0000;
    wr(ADDR_STATUS, 16'h03ff);
    wait_n(2);
    check({host_alert_out, host_alert_oe}, 16'h0000);
    wr(ADDR_CONFIG, 16'h0009);
    wait_n(2);
    check({host_alert_out, host_alert_oe}, 16'h0001);
    $display("test_load done");
  endtask : test_load

  task automatic test_uv;
    logic [15:0] d;
    wr(ADDR_OCP_ACT, 16'h0002);
    current_limit_trip <= 1'b1;
    output_uv_trip <= 1'b1;
    wait_n(5);
    check(regulator_disable, 16'h0001);
    check(output_disconnect, 16'h0001);
    rd(ADDR_STATUS, d);
    check(d & 16'h0180, 16'h0180);
    current_limit_trip <= 1'b0;
    output_uv_trip <= 1'b0;
    $display("test_uv done");
  endtask : test_uv

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    boot;
    test_hard;
    test_soft;
    test_ot;
    test_load;
    test_uv;
    @(posedge clk_sys);
    chip_reset_n <= 1'b0;
    wait_n(2);
    boot;
    stop_test;
  end
endmodule : tb_power_protection_supervisor
`default_nettype wire
